// [mgrs_top.sv]
`timescale 1ns/100ps
// What this block does
// [R1] aux level register 0x16, fields, reset 0x8888
// [R2] front dac level 0x18, same layout
// [R3] 5-bit level, 32 steps of -1.5 dB
// [R4] code 0 +12dB, 8 0dB, 31 -34.5dB
// [R5] mute bit silences channel, independent per side
// [R6] aux level never touches record adc gain
// [R7] record select 0x1a, bits 10:8 and 2:0
// [R8] source codes route inputs per channel
// [R9] reset selects code 000 both channels
// [R10] source 000: microphones swap, dual, sum
// [R11] source 001: line input replaces microphones
// [R12] source 01x: center and subwoofer pins
// [R13] source 100: mic plus center/subwoofer pairs
// [R14] swap at 0x20, other controls 0x74-0x7a
// [R15] reserved bits read zero, fields read back
module mgrs_top
(
  input wire logic clk_i,
  input wire logic rst_i,
  // ---------------------------------------------------------------
  // classic wishbone slave
  // ---------------------------------------------------------------
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // ---------------------------------------------------------------
  // mixer controls: gain in tenths of dB below +12 dB
  // ---------------------------------------------------------------
  output logic aux_left_silence_o,
  output logic aux_right_silence_o,
  output logic [8:0] aux_left_atten_o,
  output logic [8:0] aux_right_atten_o,
  output logic dac_left_silence_o,
  output logic dac_right_silence_o,
  output logic [8:0] dac_left_atten_o,
  output logic [8:0] dac_right_atten_o,
  // ---------------------------------------------------------------
  // record routing: one-hot over the eight record sources
  // ---------------------------------------------------------------
  output logic [7:0] left_record_route_o,
  output logic [7:0] right_record_route_o,
  // selector outputs: mask of summed inputs per side
  output logic [5:0] selector_left_o,
  output logic [5:0] selector_right_o
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [15:0] aux_input_level; // aux mixer level
  logic [15:0] front_dac_level; // front dac mixer level
  logic [15:0] record_source_select; // adc record source
  logic selector_swap; // exchange microphone sides
  logic [2:0] selector_source_choice; // alternate selector pins
  logic dual_capture_enable; // capture both sides at once
  logic selector_sum_enable; // sum both selector sides
  logic req; // a bus cycle is requesting
  logic hit; // the address maps to a register
  logic [15:0] wdata; // write data, low 16 bits of the bus; lanes masked later in merge or by the wb_sel_i checks
  logic [5:0] next_sel_a; // first (left/mic1) selector input
  logic [5:0] next_sel_b; // second (right/mic2) selector input
  logic [5:0] next_sel_left;
  logic [5:0] next_sel_right;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  always_comb
  begin
    case (wb_adr_i)
      mgrs_pkg::AUX_INPUT_LEVEL_ADDR,
      mgrs_pkg::FRONT_DAC_LEVEL_ADDR,
      mgrs_pkg::RECORD_SOURCE_SELECT_ADDR,
      mgrs_pkg::SELECTOR_SWAP_ADDR,
      mgrs_pkg::SELECTOR_SOURCE_ADDR,
      mgrs_pkg::DUAL_CAPTURE_ADDR,
      mgrs_pkg::SELECTOR_SUM_ADDR: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // byte lanes 0 and 1 carry the 16-bit registers; a lane not
  // selected keeps its old contents, handled per register below
  assign wdata = wb_dat_i[15:0];

  // ---------------------------------------------------------------
  // bus answer: ack or err one cycle after the request, one cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= req && hit;
      // unmapped address answers with err, nothing stored
      wb_err_o <= req && !hit;
    end
  end

  // ---------------------------------------------------------------
  // byte-lane merge for a 16-bit register
  // ---------------------------------------------------------------
  function automatic logic [15:0] merge
  (
    input logic [15:0] old,
    input logic [15:0] mask
  );
    logic [15:0] m;
    m = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    merge = ((old & ~m) | (wdata & m)) & mask; // R15
  endfunction

  // ---------------------------------------------------------------
  // level registers (aux and front dac)
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      aux_input_level <= mgrs_pkg::LEVEL_RESET; // R1
      front_dac_level <= mgrs_pkg::LEVEL_RESET; // R2
    end
    else if (req && wb_we_i)
    begin
      if (wb_adr_i == mgrs_pkg::AUX_INPUT_LEVEL_ADDR)
        aux_input_level <= merge(aux_input_level,
          mgrs_pkg::LEVEL_MASK); // R1
      if (wb_adr_i == mgrs_pkg::FRONT_DAC_LEVEL_ADDR)
        front_dac_level <= merge(front_dac_level,
          mgrs_pkg::LEVEL_MASK); // R2
    end
  end

  // ---------------------------------------------------------------
  // record source register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      record_source_select <= mgrs_pkg::RECORD_SOURCE_RESET; // R9
    else if (req && wb_we_i &&
      wb_adr_i == mgrs_pkg::RECORD_SOURCE_SELECT_ADDR)
      record_source_select <= merge(record_source_select,
        mgrs_pkg::RECORD_SOURCE_MASK); // R7
  end

  // ---------------------------------------------------------------
  // microphone selector controls, one field per register word
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      selector_swap <= 1'b0;
      selector_source_choice <= 3'h0;
      dual_capture_enable <= 1'b0;
      selector_sum_enable <= 1'b0;
    end
    else if (req && wb_we_i)
    begin
      // fields above bit 7 sit in lane 1, the rest in lane 0
      if (wb_adr_i == mgrs_pkg::SELECTOR_SWAP_ADDR && wb_sel_i[1])
        selector_swap <= wdata[mgrs_pkg::SWAP_BIT]; // R14
      if (wb_adr_i == mgrs_pkg::SELECTOR_SOURCE_ADDR && wb_sel_i[1])
        selector_source_choice <=
          wdata[mgrs_pkg::SOURCE_CHOICE_LSB +: 3]; // R14
      if (wb_adr_i == mgrs_pkg::DUAL_CAPTURE_ADDR && wb_sel_i[0])
        dual_capture_enable <= wdata[mgrs_pkg::DUAL_CAPTURE_BIT];
      if (wb_adr_i == mgrs_pkg::SELECTOR_SUM_ADDR && wb_sel_i[0])
        selector_sum_enable <= wdata[mgrs_pkg::SUM_ENABLE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // read data, registered with the ack; reserved bits read zero
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (req)
    begin
      wb_dat_o <= 32'h0000_0000; // R15
      case (wb_adr_i)
        mgrs_pkg::AUX_INPUT_LEVEL_ADDR:
          wb_dat_o[15:0] <= aux_input_level;
        mgrs_pkg::FRONT_DAC_LEVEL_ADDR:
          wb_dat_o[15:0] <= front_dac_level;
        mgrs_pkg::RECORD_SOURCE_SELECT_ADDR:
          wb_dat_o[15:0] <= record_source_select;
        mgrs_pkg::SELECTOR_SWAP_ADDR:
          wb_dat_o[mgrs_pkg::SWAP_BIT] <= selector_swap;
        mgrs_pkg::SELECTOR_SOURCE_ADDR:
          wb_dat_o[mgrs_pkg::SOURCE_CHOICE_LSB +: 3] <=
            selector_source_choice;
        mgrs_pkg::DUAL_CAPTURE_ADDR:
          wb_dat_o[mgrs_pkg::DUAL_CAPTURE_BIT] <= dual_capture_enable;
        mgrs_pkg::SELECTOR_SUM_ADDR:
          wb_dat_o[mgrs_pkg::SUM_ENABLE_BIT] <= selector_sum_enable;
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // level code to attenuation below +12 dB, tenths of a dB:
  // code 0 -> 0 (+12 dB), 8 -> 120 (0 dB), 31 -> 465 (-34.5 dB)
  // ---------------------------------------------------------------
  function automatic logic [8:0] atten(input logic [4:0] code);
    atten = 9'(code * mgrs_pkg::GAIN_STEP_TENTHS); // R3 R4
  endfunction

  // mixer outputs; mute and level drive separate outputs, and the aux level only
  // reaches the aux mixer path, never the record adc gain
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      aux_left_silence_o <= 1'b1;
      aux_right_silence_o <= 1'b1;
      dac_left_silence_o <= 1'b1;
      dac_right_silence_o <= 1'b1;
      aux_left_atten_o <= mgrs_pkg::ATTEN_RESET;
      aux_right_atten_o <= mgrs_pkg::ATTEN_RESET;
      dac_left_atten_o <= mgrs_pkg::ATTEN_RESET;
      dac_right_atten_o <= mgrs_pkg::ATTEN_RESET;
    end
    else
    begin
      aux_left_silence_o <=
        aux_input_level[mgrs_pkg::LEFT_SILENCE_BIT]; // R5
      aux_right_silence_o <=
        aux_input_level[mgrs_pkg::RIGHT_SILENCE_BIT]; // R5
      dac_left_silence_o <=
        front_dac_level[mgrs_pkg::LEFT_SILENCE_BIT]; // R5
      dac_right_silence_o <=
        front_dac_level[mgrs_pkg::RIGHT_SILENCE_BIT]; // R5
      aux_left_atten_o <= atten(
        aux_input_level[mgrs_pkg::LEFT_LEVEL_LSB +: 5]); // R6
      aux_right_atten_o <= atten(
        aux_input_level[mgrs_pkg::RIGHT_LEVEL_LSB +: 5]); // R6
      dac_left_atten_o <= atten(
        front_dac_level[mgrs_pkg::LEFT_LEVEL_LSB +: 5]);
      dac_right_atten_o <= atten(
        front_dac_level[mgrs_pkg::RIGHT_LEVEL_LSB +: 5]);
    end
  end

  // ---------------------------------------------------------------
  // record routing: each side decodes its own 3-bit code
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      left_record_route_o <= mgrs_pkg::ROUTE_RESET; // R9
      right_record_route_o <= mgrs_pkg::ROUTE_RESET; // R9
    end
    else
    begin
      left_record_route_o <= 8'h01 <<
        record_source_select[mgrs_pkg::LEFT_SOURCE_LSB +: 3]; // R8
      right_record_route_o <= 8'h01 <<
        record_source_select[mgrs_pkg::RIGHT_SOURCE_LSB +: 3]; // R8
    end
  end

  // ---------------------------------------------------------------
  // selector: pick the two candidate inputs for the source choice
  // ---------------------------------------------------------------
  always_comb
  begin
    next_sel_a = 6'h00;
    next_sel_b = 6'h00;
    next_sel_a[mgrs_pkg::SEL_MIC1] = 1'b1; // R10
    next_sel_b[mgrs_pkg::SEL_MIC2] = 1'b1; // R10
    case (selector_source_choice)
      3'h1:
      begin
        next_sel_a = 6'h01 << mgrs_pkg::SEL_LINE_L; // R11
        next_sel_b = 6'h01 << mgrs_pkg::SEL_LINE_R; // R11
      end
      3'h2, 3'h3:
      begin
        next_sel_a = 6'h01 << mgrs_pkg::SEL_CENTER; // R12
        next_sel_b = 6'h01 << mgrs_pkg::SEL_SUB; // R12
      end
      3'h4:
      begin
        next_sel_a[mgrs_pkg::SEL_CENTER] = 1'b1; // R13
        next_sel_b[mgrs_pkg::SEL_SUB] = 1'b1; // R13
      end
      3'h5:
      begin
        next_sel_a[mgrs_pkg::SEL_LINE_L] = 1'b1;
        next_sel_b[mgrs_pkg::SEL_LINE_R] = 1'b1;
      end
      3'h6:
      begin
        next_sel_a = 6'h00;
        next_sel_b = 6'h00;
        next_sel_a[mgrs_pkg::SEL_LINE_L] = 1'b1;
        next_sel_a[mgrs_pkg::SEL_CENTER] = 1'b1;
        next_sel_b[mgrs_pkg::SEL_LINE_R] = 1'b1;
        next_sel_b[mgrs_pkg::SEL_SUB] = 1'b1;
      end
      3'h7:
      begin
        next_sel_a[mgrs_pkg::SEL_LINE_L] = 1'b1;
        next_sel_a[mgrs_pkg::SEL_CENTER] = 1'b1;
        next_sel_b[mgrs_pkg::SEL_LINE_R] = 1'b1;
        next_sel_b[mgrs_pkg::SEL_SUB] = 1'b1;
      end
      default: // code 0 keeps the microphone pair set above
        next_sel_a[mgrs_pkg::SEL_MIC1] = 1'b1; // R10
    endcase
  end

  // sum, dual capture or single; sum wins over dual capture
  always_comb
  begin
    if (selector_sum_enable)
    begin
      next_sel_left = next_sel_a | next_sel_b; // R10 R11 R12 R13
      next_sel_right = next_sel_a | next_sel_b;
    end
    else if (dual_capture_enable)
    begin
      // swap exchanges the two sides
      next_sel_left = selector_swap ? next_sel_b : next_sel_a; // R14
      next_sel_right = selector_swap ? next_sel_a : next_sel_b;
    end
    else
    begin
      // single source on both sides, swap picks which one
      next_sel_left = selector_swap ? next_sel_b : next_sel_a; // R14
      next_sel_right = next_sel_left;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      selector_left_o <= mgrs_pkg::SELECTOR_RESET;
      selector_right_o <= mgrs_pkg::SELECTOR_RESET;
    end
    else
    begin
      selector_left_o <= next_sel_left;
      selector_right_o <= next_sel_right;
    end
  end

endmodule

// [mgrs_pkg.sv]
package mgrs_pkg;
  // ---------------------------------------------------------------
  // register offsets (byte addresses on the wishbone bus)
  // ---------------------------------------------------------------
  localparam logic [7:0] AUX_INPUT_LEVEL_ADDR = 8'h16;
  localparam logic [7:0] FRONT_DAC_LEVEL_ADDR = 8'h18;
  localparam logic [7:0] RECORD_SOURCE_SELECT_ADDR = 8'h1a;
  // selector control registers: each control field sits in its own
  // register word (source three bits, the others one bit) at these byte addresses
  localparam logic [7:0] SELECTOR_SWAP_ADDR = 8'h20;
  localparam logic [7:0] SELECTOR_SOURCE_ADDR = 8'h74;
  localparam logic [7:0] DUAL_CAPTURE_ADDR = 8'h76;
  localparam logic [7:0] SELECTOR_SUM_ADDR = 8'h7a;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] LEVEL_RESET = 16'h8888;
  localparam logic [15:0] RECORD_SOURCE_RESET = 16'h0000;
  // mixer outputs follow the level default: code 8 is 0 dB
  localparam logic [8:0] ATTEN_RESET = 9'h078;
  // record routing and selector outputs start on the microphone path
  localparam logic [7:0] ROUTE_RESET = 8'h01;
  localparam logic [5:0] SELECTOR_RESET = 6'h01;
  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int LEFT_SILENCE_BIT = 15;
  localparam int RIGHT_SILENCE_BIT = 7;
  localparam int LEFT_LEVEL_LSB = 8;
  localparam int RIGHT_LEVEL_LSB = 0;
  localparam int LEFT_SOURCE_LSB = 8;
  localparam int RIGHT_SOURCE_LSB = 0;
  localparam int SWAP_BIT = 8;
  localparam int SOURCE_CHOICE_LSB = 8;
  localparam int DUAL_CAPTURE_BIT = 6;
  localparam int SUM_ENABLE_BIT = 2;
  localparam logic [15:0] LEVEL_MASK = 16'h9f9f;
  localparam logic [15:0] RECORD_SOURCE_MASK = 16'h0707;
  // ---------------------------------------------------------------
  // record source codes
  // ---------------------------------------------------------------
  localparam logic [2:0] REC_SELECTOR = 3'h0;
  localparam logic [2:0] REC_DISC = 3'h1;
  localparam logic [2:0] REC_MUTED = 3'h2;
  localparam logic [2:0] REC_AUX = 3'h3;
  localparam logic [2:0] REC_LINE = 3'h4;
  localparam logic [2:0] REC_STEREO_MIX = 3'h5;
  localparam logic [2:0] REC_MONO_MIX = 3'h6;
  localparam logic [2:0] REC_PHONE = 3'h7;
  // ---------------------------------------------------------------
  // selector input one-hot bits
  // ---------------------------------------------------------------
  localparam int SEL_MIC1 = 0;
  localparam int SEL_MIC2 = 1;
  localparam int SEL_LINE_L = 2;
  localparam int SEL_LINE_R = 3;
  localparam int SEL_CENTER = 4;
  localparam int SEL_SUB = 5;
  // level code figures, in tenths of a dB
  localparam int GAIN_TOP_TENTHS = 120;
  localparam int GAIN_STEP_TENTHS = 15;
endpackage

// [mgrs_properties.sv]
`timescale 1ns/100ps
// ---------------------------------------------------------------
// bus and output checker for the mixer register slice
// ---------------------------------------------------------------
module mgrs_checker
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic [8:0] aux_left_atten_o,
  input wire logic dac_right_silence_o,
  input wire logic [7:0] left_record_route_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // request accepted at this edge
  logic take;
  // address hits one of the seven register words
  logic hit;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign hit = wb_adr_i inside {8'h16, 8'h18, 8'h1a, 8'h20, 8'h74,
    8'h76, 8'h7a};
  AST_ACK_NEXT: assert property (take && hit |=> wb_ack_o && !wb_err_o)
    else $error("mapped request not acknowledged");
  AST_ERR_NEXT: assert property (take && !hit |=> wb_err_o && !wb_ack_o)
    else $error("unmapped request not refused");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  // output lags the stored value by one edge
  AST_AUX_LEVEL: assert property (take && wb_we_i && wb_adr_i == 8'h16 &&
    wb_sel_i[1] |-> ##2
    aux_left_atten_o == 9'($past(wb_dat_i[12:8], 2)) * 9'd15)
    else $error("aux left attenuation wrong");
  AST_DAC_MUTE: assert property (take && wb_we_i && wb_adr_i == 8'h18 &&
    wb_sel_i[0] |-> ##2 dac_right_silence_o == $past(wb_dat_i[7], 2))
    else $error("dac right silence wrong");
  AST_ROUTE: assert property (take && wb_we_i && wb_adr_i == 8'h1a &&
    wb_sel_i[1] |-> ##2
    left_record_route_o == 8'h01 << $past(wb_dat_i[10:8], 2))
    else $error("left record route wrong");
  AST_RD_RESV: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i == 8'h1a |-> (wb_dat_o & 32'hffff_f8f8) == 32'h0000_0000)
    else $error("reserved record select bits read nonzero");
  AST_ERR_DATA: assert property (wb_err_o |-> wb_dat_o == 32'h0000_0000)
    else $error("refused access returned data");
  COV_REFUSE: cover property (take && !hit);
  COV_ROUTE_WR: cover property (take && wb_we_i && wb_adr_i == 8'h1a);
  COV_READ: cover property (take && !wb_we_i);
endmodule
bind mgrs_top mgrs_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .aux_left_atten_o(aux_left_atten_o),
  .dac_right_silence_o(dac_right_silence_o),
  .left_record_route_o(left_record_route_o));

// [mgrs_host_model.sv]
`timescale 1ns/100ps
// ---------------------------------------------------------------
// audio controller side: classic wishbone single-cycle master
// ---------------------------------------------------------------
module mgrs_host_model
(
  input wire logic clk_i,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i,
  input wire logic wb_err_i
);
  // idle bus at time zero
  initial
  begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0000_0000;
  end
  // one transfer; ok stays low if the slave never answers
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [3:0] s, input logic [31:0] d, output logic [31:0] q,
    output logic e, output logic ok);
    ok = 1'b0;
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= w;
    wb_adr_o <= a;
    wb_sel_o <= s;
    wb_dat_o <= d;
    for (int n = 0; n < 20 && !ok; n++)
    begin
      @(posedge clk_i);
      if (wb_ack_i === 1'b1 || wb_err_i === 1'b1)
      begin
        ok = 1'b1;
        q = wb_dat_i;
        e = wb_err_i;
      end
    end
    // released data lines must not look like the old value
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_dat_o <= ~d;
  endtask
endmodule

// [mixer_gain_and_record_select_tb_top.sv]
`timescale 1ns/100ps
`define CHK(n, e, v) begin checked++; if ((v) !== (e)) begin \
  fail_count++; $display("MISMATCH %s expected %h seen %h", n, e, v); \
  end end
module mixer_gain_and_record_select_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, err, e, ok;
  logic [7:0] adr, rt_l, rt_r;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic aux_ls, aux_rs, dac_ls, dac_rs;
  logic [8:0] aux_la, aux_ra, dac_la, dac_ra;
  logic [5:0] sl_l, sl_r;
  logic [2:0] k;
  logic [17:0] t;
  int fail_count = 0;
  int checked = 0;
  // selector cases: source, sum, dual, swap, left mask, right mask
  logic [17:0] tv [13] = '{{3'h0, 3'h0, 6'h01, 6'h01},
    {3'h0, 3'h1, 6'h02, 6'h02}, {3'h0, 3'h3, 6'h02, 6'h01},
    {3'h0, 3'h4, 6'h03, 6'h03}, {3'h1, 3'h2, 6'h04, 6'h08},
    {3'h1, 3'h7, 6'h0c, 6'h0c}, {3'h2, 3'h1, 6'h20, 6'h20},
    {3'h3, 3'h3, 6'h20, 6'h10}, {3'h4, 3'h2, 6'h11, 6'h22},
    {3'h4, 3'h7, 6'h33, 6'h33}, {3'h5, 3'h1, 6'h0a, 6'h0a},
    {3'h6, 3'h2, 6'h14, 6'h28}, {3'h7, 3'h4, 6'h3f, 6'h3f}};
  always #5 clk_i = ~clk_i;
  mgrs_host_model u_host (.clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb),
    .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat),
    .wb_dat_i(rdat), .wb_ack_i(ack), .wb_err_i(err));
  mgrs_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .aux_left_silence_o(aux_ls), .aux_right_silence_o(aux_rs),
    .aux_left_atten_o(aux_la), .aux_right_atten_o(aux_ra),
    .dac_left_silence_o(dac_ls), .dac_right_silence_o(dac_rs),
    .dac_left_atten_o(dac_la), .dac_right_atten_o(dac_ra),
    .left_record_route_o(rt_l), .right_record_route_o(rt_r),
    .selector_left_o(sl_l), .selector_right_o(sl_r));
  // ---------------------------------------------------------------
  // bus helpers and the single exit point
  // ---------------------------------------------------------------
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // a silent slave counts as a mismatch and ends the run
  task automatic xf(input logic w, input logic [7:0] a,
    input logic [15:0] d, input logic [3:0] s);
    u_host.xfer(w, a, s, {16'h0000, d}, q, e, ok);
    if (!ok)
    begin
      fail_count++;
      test_done;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
    input logic [3:0] s);
    xf(1'b1, a, d, s);
    `CHK("write refused", 1'b0, e)
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    xf(1'b0, a, 16'h0000, 4'hf);
    `CHK("read data", {16'h0000, x}, q)
  endtask
  // outputs trail the register by one edge
  task automatic settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    settle;
    `CHK("aux", 20'h9_e278, {aux_ls, aux_la, aux_rs, aux_ra})
    `CHK("dac", 20'h9_e278, {dac_ls, dac_la, dac_rs, dac_ra})
    `CHK("route", 16'h0101, {rt_l, rt_r})
    `CHK("selector", 12'h041, {sl_l, sl_r})
    rd(8'h16, 16'h8888);
    rd(8'h18, 16'h8888);
    rd(8'h1a, 16'h0000);
    $display("test reset done");
    // end codes, reserved bits, mute independence, lanes
    wr(8'h16, 16'hffff, 4'h3);
    rd(8'h16, 16'h9f9f);
    settle;
    `CHK("aux", 20'hf_47d1, {aux_ls, aux_la, aux_rs, aux_ra})
    wr(8'h16, 16'h0000, 4'h3);
    settle;
    `CHK("aux", 20'h0_0000, {aux_ls, aux_la, aux_rs, aux_ra})
    wr(8'h16, 16'h8a08, 4'h3);
    settle;
    `CHK("aux", 20'ha_5878, {aux_ls, aux_la, aux_rs, aux_ra})
    `CHK("dac", 20'h9_e278, {dac_ls, dac_la, dac_rs, dac_ra})
    wr(8'h18, 16'h0000, 4'h1);
    rd(8'h18, 16'h8800);
    wr(8'h18, 16'h1f1f, 4'h3);
    settle;
    `CHK("dac", 20'h7_45d1, {dac_ls, dac_la, dac_rs, dac_ra})
    $display("test levels done");
    for (int c = 0; c < 8; c++)
    begin
      k = c[2:0];
      wr(8'h1a, {5'h1f, k, 5'h1f, ~k}, 4'h3);
      rd(8'h1a, {5'h00, k, 5'h00, ~k});
      settle;
      `CHK("route", {8'h01 << k, 8'h01 << ~k}, {rt_l, rt_r})
    end
    $display("test routes done");
    for (int i = 0; i < 13; i++)
    begin
      t = tv[i];
      wr(8'h74, {5'h1f, t[17:15], 8'hff}, 4'h3);
      rd(8'h74, {5'h00, t[17:15], 8'h00});
      wr(8'h7a, {13'h0000, t[14], 2'b00}, 4'h3);
      wr(8'h76, {9'h000, t[13], 6'h00}, 4'h3);
      wr(8'h20, {7'h00, t[12], 8'h00}, 4'h3);
      settle;
      `CHK("selector", t[11:0], {sl_l, sl_r})
    end
    $display("test selector done");
    // the record gain word is not part of this slice
    xf(1'b1, 8'h1c, 16'h0000, 4'h3);
    `CHK("refuse write", 1'b1, e)
    xf(1'b0, 8'h1c, 16'h0000, 4'hf);
    `CHK("refuse read", {1'b1, 32'h0000_0000}, {e, q})
    rd(8'h16, 16'h8a08);
    $display("test refusal done");
    // a reset in mid-run must bring every default back
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    settle;
    `CHK("selector", 12'h041, {sl_l, sl_r})
    `CHK("route", 16'h0101, {rt_l, rt_r})
    rd(8'h16, 16'h8888);
    rd(8'h74, 16'h0000);
    $display("test second reset done");
    test_done;
  end
endmodule
